// >>> verilog/single_wire_reference_programmer.sv
// Single-wire mode detection, bit decoder and acknowledge for the control pin.
// Behaviour
// - Address byte then ack, subaddress, level byte.
// - Bits arrive and assemble MSB first.
// - Long low after byte closes the byte.
// - Bit measured between successive falling edges.
// - One if high twice low, zero reverse.
// - Ack needs request, address match, sixteen bits.
// - Ack after validity delay, low 512 us max.
// - Ack is open-drain pulldown only.
// - Mode chosen at each enable, default duty.
// - Detection pulse must complete within window.
// - Enter mode at once, accept early traffic.
// - Mode latched until shutdown and restart.
// - Five-bit level register resets full scale.
// - Low beyond 2.5 ms shuts down, clears mode.
// - Default mode gates reference by duty cycle.
// - Decoder is rate independent across range.
`timescale 1ns/100ps
`default_nettype none
module single_wire_reference_programmer #(
  parameter logic [7:0]  DEVICE_ADDR  = 8'h5a, // Arbitrary value.
  parameter int unsigned SHUTDOWN_CYC = swire_pkg::SHUTDOWN_CYC
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       clk_en_i,
  input  wire logic       ctrl_line_i,
  output logic            ctrl_line_o,
  output logic            ctrl_line_oe_o,
  output logic            enabled_o,
  output logic            one_wire_mode_o,
  output logic            ref_gate_o,
  output logic [4:0]      level_o,
  output logic            frame_done_o
);
  localparam int W = swire_pkg::CNT_W;
  typedef enum logic [2:0] {
    M_OFF, M_DELAY, M_WAIT_LOW, M_DET_LOW, M_DUTY, M_WIRE
  } mode_e;

  logic          sync1_r, sync2_r, line_r;
  mode_e         mode_r;
  logic [W-1:0]  low_cnt_r, win_cnt_r, hi_cnt_r, lo_cnt_r;
  logic          in_bit_r;
  logic [15:0]   shift_r;
  logic [4:0]    nbits_r;
  logic          bad_r, byte_open_r;
  logic          ack_wait_r, ack_drive_r;
  logic [W-1:0]  ack_cnt_r;
  logic [4:0]    level_r;
  logic          done_r;
  logic          fall, rise, powered_off, bit_val, bit_ok;
  logic          eos, frame_ok, ack_busy;

  // Two stages before use; the second and a third, delayed copy of it are looked at.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      line_r  <= 1'b0;
    end else if (clk_en_i) begin
      sync1_r <= ctrl_line_i;
      sync2_r <= sync1_r;
      line_r  <= sync2_r;
    end
  end

  // While the device pulls the line, our own low must not look like traffic.
  assign ack_busy = ack_drive_r;
  assign fall = line_r & ~sync2_r & ~ack_busy;
  assign rise = ~line_r & sync2_r;

  // Continuous low timer feeds shutdown.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      low_cnt_r <= '0;
    end else if (clk_en_i) begin
      if (sync2_r) begin
        low_cnt_r <= '0;
      end else if (low_cnt_r != W'(SHUTDOWN_CYC)) begin
        low_cnt_r <= low_cnt_r + 1'b1;
      end
    end
  end
  assign powered_off = ~sync2_r && (low_cnt_r == W'(SHUTDOWN_CYC - 1));

  // Mode selection, redone after every shutdown.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mode_r    <= M_OFF;
      win_cnt_r <= '0;
    end else if (clk_en_i) begin
      if (mode_r != M_OFF && win_cnt_r != W'(swire_pkg::DET_WIN_CYC)) begin
        win_cnt_r <= win_cnt_r + 1'b1;
      end
      if (powered_off && mode_r != M_OFF) begin
        mode_r <= M_OFF;
      end else begin
        case (mode_r)
          M_OFF: begin
            if (rise) begin
              mode_r    <= M_DELAY;
              win_cnt_r <= '0;
            end
          end
          M_DELAY: begin
            if (win_cnt_r >= W'(swire_pkg::DET_DELAY_CYC)) begin
              mode_r <= M_WAIT_LOW;
            end else if (!sync2_r) begin
              mode_r <= M_DUTY;
            end
          end
          M_WAIT_LOW: begin
            if (win_cnt_r >= W'(swire_pkg::DET_WIN_CYC)) begin
              mode_r <= M_DUTY;
            end else if (!sync2_r) begin
              mode_r <= M_DET_LOW;
            end
          end
          M_DET_LOW: begin
            if (low_cnt_r >= W'(swire_pkg::DET_LOW_CYC)) begin
              mode_r <= M_WIRE;
            end else if (win_cnt_r >= W'(swire_pkg::DET_WIN_CYC)) begin
              mode_r <= M_DUTY;
            end else if (sync2_r) begin
              mode_r <= M_DUTY;
            end
          end
          M_DUTY:  mode_r <= M_DUTY;
          M_WIRE:  mode_r <= M_WIRE;
          default: mode_r <= M_OFF;
        endcase
      end
    end
  end

  // Rate-free ratio compare of high and low time within one bit.
  assign bit_val = (hi_cnt_r >= {lo_cnt_r[W-2:0], 1'b0});
  assign bit_ok  = bit_val ||
                   ({hi_cnt_r[W-2:0], 1'b0} <= lo_cnt_r);
  // A byte closes on a long low after its last fall. A zero whose low
  // outlasts that spell would close the byte early, which bounds the
  // slowest usable bit rate.
  assign eos = in_bit_r && !sync2_r && lo_cnt_r >= W'(swire_pkg::EOS_CYC);

  // Bit period timers between falling edges.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || mode_r != M_WIRE) begin
      in_bit_r <= 1'b0;
      hi_cnt_r <= '0;
      lo_cnt_r <= '0;
    end else if (clk_en_i) begin
      if (fall) begin
        in_bit_r <= 1'b1;
        lo_cnt_r <= '0;
        hi_cnt_r <= '0;
      end else if (eos) begin
        in_bit_r <= 1'b0;
      end else if (in_bit_r && !sync2_r) begin
        lo_cnt_r <= lo_cnt_r + 1'b1;
      end else if (in_bit_r) begin
        hi_cnt_r <= hi_cnt_r + 1'b1;
      end
    end
  end

  // Bit assembly; every fall inside a byte closes the bit before it.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || mode_r != M_WIRE) begin
      shift_r     <= '0;
      nbits_r     <= '0;
      bad_r       <= 1'b0;
      byte_open_r <= 1'b0;
      done_r      <= 1'b0;
    end else if (clk_en_i) begin
      done_r <= 1'b0;
      if (in_bit_r && fall) begin
        shift_r <= {shift_r[14:0], bit_val};
        nbits_r <= nbits_r + 1'b1;
        if (!bit_ok) begin
          bad_r <= 1'b1;
        end
      end
      if (eos) begin
        if (nbits_r == 5'(swire_pkg::BITS_PER_FRAME)) begin
          done_r  <= 1'b1;
          nbits_r <= '0;
        end else if (nbits_r != 5'd8) begin
          nbits_r <= '0;
          bad_r   <= 1'b0;
        end
      end else if (done_r) begin
        // Cleared only after the frame check has seen it.
        bad_r <= 1'b0;
      end
    end
  end

  // A frame counts only when every bit had a clean ratio.
  always_comb begin
    frame_ok = done_r && !bad_r && shift_r[15:8] == DEVICE_ADDR;
  end

  // Stored level, only on matching frames with zero sub-address.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || mode_r == M_OFF) begin
      level_r <= swire_pkg::LEVEL_RESET;
    end else if (clk_en_i && frame_ok &&
                 shift_r[swire_pkg::SUB_HI:swire_pkg::SUB_LO] ==
                 swire_pkg::SUBADDR_OK) begin
      level_r <= shift_r[4:0];
    end
  end

  // Acknowledge: wait validity delay, then pull low a bounded time.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || mode_r != M_WIRE) begin
      ack_wait_r  <= 1'b0;
      ack_drive_r <= 1'b0;
      ack_cnt_r   <= '0;
    end else if (clk_en_i) begin
      // The validity delay runs from the last fall, and the close has
      // already used up the end-of-stream spell of it.
      if (frame_ok && shift_r[swire_pkg::ACK_BIT]) begin
        ack_wait_r <= 1'b1;
        ack_cnt_r  <= W'(swire_pkg::EOS_CYC);
      end else if (ack_wait_r) begin
        ack_cnt_r <= ack_cnt_r + 1'b1;
        if (ack_cnt_r >= W'(swire_pkg::ACK_VALID_CYC)) begin
          ack_wait_r  <= 1'b0;
          ack_drive_r <= 1'b1;
          ack_cnt_r   <= '0;
        end
      end else if (ack_drive_r) begin
        ack_cnt_r <= ack_cnt_r + 1'b1;
        if (ack_cnt_r == W'(swire_pkg::ACK_LOW_CYC - 1)) begin
          ack_drive_r <= 1'b0;
        end
      end
    end
  end

  // The pin is open drain, so only its enable ever moves.
  assign ctrl_line_o     = 1'b0;
  assign ctrl_line_oe_o  = ack_drive_r;
  assign enabled_o       = (mode_r != M_OFF);
  assign one_wire_mode_o = (mode_r == M_WIRE);
  assign ref_gate_o      = (mode_r != M_OFF) && (mode_r != M_WIRE) && sync2_r;
  assign level_o         = level_r;
  assign frame_done_o    = done_r;
endmodule
`default_nettype wire

// >>> inc/swire_pkg.sv
// Constants for the single-wire reference programmer.
package swire_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  // Times in nanoseconds, counts derived at the clock rate.
  localparam longint unsigned START_NS = 2_000;
  localparam longint unsigned EOS_NS = 2_000;
  localparam longint unsigned DET_DELAY_NS = 100_000;
  localparam longint unsigned DET_LOW_NS = 260_000;
  localparam longint unsigned DET_WIN_NS = 1_000_000;
  localparam longint unsigned SHUTDOWN_NS = 2_500_000;
  localparam longint unsigned ACK_MAX_NS = 512_000;
  localparam longint unsigned ACK_VALID_NS = 2_000;
  localparam longint unsigned NS_PER_S = 1_000_000_000;
  localparam int unsigned EOS_CYC =
    int'((EOS_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
  localparam int unsigned DET_DELAY_CYC =
    int'((DET_DELAY_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
  localparam int unsigned DET_LOW_CYC =
    int'((DET_LOW_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
  localparam int unsigned DET_WIN_CYC = int'((DET_WIN_NS * CLK_HZ) / NS_PER_S);
  localparam int unsigned SHUTDOWN_CYC =
    int'((SHUTDOWN_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
  localparam int unsigned ACK_LOW_CYC = int'((ACK_MAX_NS * CLK_HZ) / NS_PER_S);
  localparam int unsigned ACK_VALID_CYC =
    int'((ACK_VALID_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
  localparam int CNT_W = 18;
  localparam logic [4:0] LEVEL_RESET = 5'h1f;
  localparam logic [1:0] SUBADDR_OK = 2'h0;
  localparam int ACK_BIT = 7;
  localparam int SUB_HI = 6;
  localparam int SUB_LO = 5;
  localparam int BITS_PER_FRAME = 16;
endpackage

// >>> sim/swire_chk.sv
// Port assertions for the reference programmer.
`timescale 1ns/100ps
`default_nettype none
module swire_chk #(
  parameter int unsigned SHUTDOWN_CYC = 2000
) (
  input wire logic       ref_clk_i,
  input wire logic       rst_i,
  input wire logic       ctrl_line_i,
  input wire logic       ctrl_line_o,
  input wire logic       ctrl_line_oe_o,
  input wire logic       enabled_o,
  input wire logic       one_wire_mode_o,
  input wire logic [4:0] level_o,
  input wire logic       frame_done_o
);
  int unsigned low_cnt;
  int unsigned ack_cnt;
  int unsigned since_done;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge ref_clk_i) begin
    low_cnt <= (rst_i || ctrl_line_i) ? 0 : low_cnt + 1;
  end
  always_ff @(posedge ref_clk_i) begin
    ack_cnt <= ctrl_line_oe_o ? ack_cnt + 1 : 0;
  end
  // Saturates so a long idle spell never wraps into a false match.
  always_ff @(posedge ref_clk_i) begin
    if (frame_done_o) begin
      since_done <= 0;
    end else if (since_done < 1000) begin
      since_done <= since_done + 1;
    end
  end
  sequence ack_run;
    ctrl_line_oe_o [*8];
  endsequence
  odrain_only_a: assert property (ctrl_line_o == 1'h0)
    else $error("control line driven high");
  reset_state_a: assert property ($fell(rst_i) |-> level_o == 5'h1f &&
    !one_wire_mode_o && !ctrl_line_oe_o && !enabled_o)
    else $error("state after reset wrong");
  ack_in_mode_a: assert property (ctrl_line_oe_o |-> one_wire_mode_o)
    else $error("ack outside one-wire mode");
  ack_delay_a: assert property ($rose(ctrl_line_oe_o) |->
    low_cnt >= swire_pkg::ACK_VALID_CYC &&
    low_cnt <= swire_pkg::ACK_VALID_CYC + 16)
    else $error("ack not after validity delay");
  ack_cause_a: assert property ($rose(ctrl_line_oe_o) |->
    since_done >= 1 && since_done <= 2)
    else $error("ack not tied to frame close");
  ack_hold_a: assert property ($rose(ctrl_line_oe_o) |-> ack_run)
    else $error("ack pulse too short");
  ack_limit_a: assert property (ack_cnt <= swire_pkg::ACK_LOW_CYC)
    else $error("ack pulse too long");
  level_cause_a: assert property ($changed(level_o) && enabled_o &&
    !$past(rst_i) |-> $past(frame_done_o))
    else $error("level changed without frame");
  mode_needs_en_a: assert property (one_wire_mode_o |-> enabled_o)
    else $error("mode set while shut down");
  shutdown_a: assert property (low_cnt > SHUTDOWN_CYC + 8 |->
    !enabled_o && !one_wire_mode_o)
    else $error("no shutdown on long low");
  mode_kept_a: assert property ($fell(one_wire_mode_o) |-> !enabled_o)
    else $error("mode left without shutdown");
endmodule
bind single_wire_reference_programmer swire_chk #(
  .SHUTDOWN_CYC(SHUTDOWN_CYC)
) u_chk (.ref_clk_i, .rst_i, .ctrl_line_i, .ctrl_line_o, .ctrl_line_oe_o,
  .enabled_o, .one_wire_mode_o, .level_o, .frame_done_o);
`default_nettype wire

// >>> sim/swire_host.sv
// Host model that works the control wire through an open-drain stage.
`timescale 1ns/100ps
`default_nettype none
module swire_host (
  input  wire logic ref_clk_i,
  output logic      pull_low_o
);
  // Open-drain only, so the host may ask for an ack safely.
  initial pull_low_o = 1'h1;
  task automatic hold(input logic lvl, input int n);
    pull_low_o <= !lvl;
    repeat (n) @(posedge ref_clk_i);
  endtask
  // Even halves give a bit that meets neither ratio.
  task automatic send_byte(input logic [7:0] b, input logic even);
    hold(1'h1, 120);
    for (int i = 7; i >= 0; i--) begin
      if (even) begin
        hold(1'h0, 40);
        hold(1'h1, 40);
      end else begin
        hold(1'h0, b[i] ? 20 : 60);
        hold(1'h1, b[i] ? 60 : 20);
      end
    end
    hold(1'h0, 150);
  endtask
  task automatic frame(input logic [7:0] a, input logic [7:0] d,
                       input logic even);
    send_byte(a, 1'h0);
    send_byte(d, even);
    hold(1'h1, 20);
  endtask
  task automatic detect();
    hold(1'h1, 5100);
    hold(1'h0, 13100);
    hold(1'h1, 200);
  endtask
endmodule
`default_nettype wire

// >>> sim/test_single_wire_reference_programmer.sv
// Self-checking bench for the reference programmer.
`timescale 1ns/100ps
`default_nettype none
module test_single_wire_reference_programmer;
  localparam int unsigned SHUT = 30000;
  logic       ref_clk_i;
  logic       rst_i;
  logic       pull_low;
  logic       line;
  logic       oe;
  logic       enabled;
  logic       mode;
  logic       gate;
  logic [4:0] level;
  logic       done;
  int         fails = 0;
  int         comparisons = 0;
  int         cycles = 0;
  // Pull-up wins unless host or device sinks the wire.
  assign line = !(pull_low || oe);
  swire_host u_host (.ref_clk_i(ref_clk_i), .pull_low_o(pull_low));
  single_wire_reference_programmer #(.SHUTDOWN_CYC(SHUT)) u_dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(1'h1),
    .ctrl_line_i(line), .ctrl_line_o(), .ctrl_line_oe_o(oe),
    .enabled_o(enabled), .one_wire_mode_o(mode), .ref_gate_o(gate),
    .level_o(level), .frame_done_o(done));
  initial begin
    ref_clk_i = 1'h0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  task automatic conclude();
    if (fails == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 98000) begin
      fails++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [4:0] e, input logic [4:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick();
    @(posedge ref_clk_i);
    #1;
  endtask
  task automatic xfer(input logic [7:0] a, input logic [7:0] d,
                      input logic even);
    int n;
    n = 0;
    fork
      u_host.frame(a, d, even);
      while (done !== 1'h1 && n < 4000) begin
        tick();
        n++;
      end
    join
    chk("frame_done", 5'h1, {4'h0, n < 4000});
    tick();
  endtask
  task automatic t_write();
    xfer(8'h5a, 8'h0c, 1'h0);
    chk("level", 5'h0c, level);
    chk("ack_off", 5'h0, {4'h0, oe});
  endtask
  task automatic t_refuse();
    xfer(8'h5a, 8'h9f, 1'h1);
    chk("bad_ratio", 5'h0c, level);
    repeat (300) tick();
    chk("ratio_no_ack", 5'h0, {4'h0, oe});
    xfer(8'h5b, 8'h93, 1'h0);
    chk("bad_addr", 5'h0c, level);
    repeat (300) tick();
    chk("no_ack", 5'h0, {4'h0, oe});
    xfer(8'h5a, 8'h33, 1'h0);
    chk("sub_01", 5'h0c, level);
    xfer(8'h5a, 8'h53, 1'h0);
    chk("sub_10", 5'h0c, level);
  endtask
  task automatic t_ack();
    int n;
    n = 0;
    xfer(8'h5a, 8'h85, 1'h0);
    chk("ack_level", 5'h05, level);
    while (oe !== 1'h1 && n < 400) begin
      tick();
      n++;
    end
    chk("ack_wire", 5'h0, {4'h0, line});
    n = 0;
    while (oe === 1'h1 && n < 26000) begin
      tick();
      n++;
    end
    chk("ack_len", 5'h1, {4'h0, n > 25000 && n <= 25600});
    chk("released", 5'h1, {4'h0, line});
  endtask
  task automatic t_shutdown();
    u_host.hold(1'h0, SHUT + 200);
    #1;
    chk("shut_mode", 5'h0, {3'h0, enabled, mode});
    chk("shut_level", 5'h1f, level);
    // A low inside the detect delay keeps the duty mode.
    u_host.hold(1'h1, 1000);
    u_host.hold(1'h0, 500);
    u_host.hold(1'h1, 2000);
    #1;
    chk("duty_mode", 5'h2, {3'h0, enabled, mode});
    chk("gate_high", 5'h1, {4'h0, gate});
    u_host.hold(1'h0, 50);
    #1;
    chk("gate_low", 5'h0, {4'h0, gate});
  endtask
  initial begin
    rst_i = 1'h1;
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'h0;
    tick();
    chk("reset", 5'h1f, level);
    chk("reset_st", 5'h0, {2'h0, enabled, mode, oe});
    u_host.detect();
    #1;
    chk("one_wire", 5'h3, {3'h0, enabled, mode});
    t_write();
    t_refuse();
    t_ack();
    t_shutdown();
    conclude();
  end
endmodule
`default_nettype wire
